// ---- design/led_gpio_pin_strap_pkg.sv ----
// shared constants and carrier types for the led/gpio strap pin mux
package led_gpio_pin_strap_pkg;

    // management address width and strap-dependent defaults
    localparam int unsigned ADDR_W        = 5;
    localparam logic [4:0]  VPHY_ADDR_S0  = 5'h00;
    localparam logic [4:0]  PORT1_ADDR_S0 = 5'h01;
    localparam logic [4:0]  PORT2_ADDR_S0 = 5'h02;
    localparam logic [4:0]  ADDR_STEP_S1  = 5'h01;

    // reset value of the captured strap (pin has a pull-up)
    localparam logic        STRAP_RST     = 1'b1;

    // indicator driver function field encodings
    localparam logic [1:0]  FUN_PUSH_PULL = 2'h0;

    // gpio buffer modes
    typedef enum logic [2:0] {
        GIO_INPUT      = 3'b001,
        GIO_PUSH_PULL  = 3'b010,
        GIO_OPEN_DRAIN = 3'b100
    } gio_mode_t;

    // capture sequencing
    typedef enum logic [1:0] {
        ST_WAIT = 2'b01,
        ST_HELD = 2'b10
    } cap_state_t;

    // management address triple
    typedef struct packed {
        logic [4:0] vphy;
        logic [4:0] port1;
        logic [4:0] port2;
    } mgmt_addr_t;

    // pin drive pair
    typedef struct packed {
        logic out;
        logic oe;
    } pin_drive_t;

    // all module state
    typedef struct packed {
        cap_state_t st;
        logic       strap;
        logic       ovr_valid;
        logic       ovr_strap;
        pin_drive_t pin;
        logic       gio_in;
    } state_t;

endpackage

// ---- design/led_gpio_pin_strap_select.sv ----
// pin mux for indicator five / general io five with address and polarity strap
`timescale 1ns/1ns
module led_gpio_pin_strap_select (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_external_reset_n,
    // strap pin level and loader override
    input  wire logic        i_addr_and_polarity_strap,
    input  wire logic        i_loader_ovr_valid,
    input  wire logic        i_loader_ovr_strap,
    // indicator config
    input  wire logic        i_indicator_enable,
    input  wire logic [1:0]  i_indicator_driver_function,
    input  wire logic        i_indicator_active,
    // general io config
    input  wire logic        i_gio_dir_out,
    input  wire logic        i_gio_open_drain,
    input  wire logic        i_gio_data_out,
    // shared pin
    input  wire logic        i_pin,
    output logic             o_pin,
    output logic             o_pin_oe,
    // status
    output logic             o_strap_latched,
    output logic             o_strap_captured,
    output logic             o_gio_data_in,
    output logic [4:0]       o_vphy_addr,
    output logic [4:0]       o_port1_addr,
    output logic [4:0]       o_port2_addr
);

    ////////////////////////////////////////////////////////////////////////////
    // decode helpers

    // strap to address triple; sums are cut to the field width on purpose
    function automatic led_gpio_pin_strap_pkg::mgmt_addr_t addr_of(input logic s);
        led_gpio_pin_strap_pkg::mgmt_addr_t a;
        a.vphy  = led_gpio_pin_strap_pkg::VPHY_ADDR_S0;
        a.port1 = led_gpio_pin_strap_pkg::PORT1_ADDR_S0;
        a.port2 = led_gpio_pin_strap_pkg::PORT2_ADDR_S0;
        if (s) begin
            a.vphy  = 5'(a.vphy + led_gpio_pin_strap_pkg::ADDR_STEP_S1);
            a.port1 = 5'(a.port1 + led_gpio_pin_strap_pkg::ADDR_STEP_S1);
            a.port2 = 5'(a.port2 + led_gpio_pin_strap_pkg::ADDR_STEP_S1);
        end
        return a;
    endfunction

    led_gpio_pin_strap_pkg::state_t     s_r;
    led_gpio_pin_strap_pkg::state_t     s_nxt;
    led_gpio_pin_strap_pkg::gio_mode_t  gmode;
    led_gpio_pin_strap_pkg::mgmt_addr_t addr;
    logic                               eff_strap;

    ////////////////////////////////////////////////////////////////////////////
    // effective strap and general io mode

    // override wins once loaded; raw capture stays visible on its own port
    assign eff_strap = s_r.ovr_valid ? s_r.ovr_strap : s_r.strap;
    assign addr      = addr_of(eff_strap);

    always_comb begin
        if (!i_gio_dir_out) begin
            gmode = led_gpio_pin_strap_pkg::GIO_INPUT;
        end else if (i_gio_open_drain) begin
            gmode = led_gpio_pin_strap_pkg::GIO_OPEN_DRAIN;
        end else begin
            gmode = led_gpio_pin_strap_pkg::GIO_PUSH_PULL;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        s_nxt        = s_r;
        s_nxt.gio_in = i_pin;
        // strap is sampled once, in the first cycle after reset release
        case (s_r.st)
            led_gpio_pin_strap_pkg::ST_WAIT: begin
                s_nxt.strap = i_addr_and_polarity_strap;
                s_nxt.st    = led_gpio_pin_strap_pkg::ST_HELD;
            end
            led_gpio_pin_strap_pkg::ST_HELD: begin
                if (i_loader_ovr_valid) begin
                    s_nxt.ovr_valid = 1'b1;
                    s_nxt.ovr_strap = i_loader_ovr_strap;
                end
            end
            default: s_nxt.st = led_gpio_pin_strap_pkg::ST_WAIT;
        endcase
        // pin drive; held released until the strap is known
        s_nxt.pin = '0;
        if (s_r.st == led_gpio_pin_strap_pkg::ST_HELD) begin
            if (i_indicator_enable) begin
                if (i_indicator_driver_function ==
                    led_gpio_pin_strap_pkg::FUN_PUSH_PULL) begin
                    s_nxt.pin.out = i_indicator_active;
                    s_nxt.pin.oe  = 1'b1;
                end else begin
                    // strap 0 active high, strap 1 active low
                    s_nxt.pin.out = eff_strap ? 1'b0 : 1'b1;
                    s_nxt.pin.oe  = i_indicator_active;
                end
            end else begin
                case (gmode)
                    led_gpio_pin_strap_pkg::GIO_PUSH_PULL: begin
                        s_nxt.pin.out = i_gio_data_out;
                        s_nxt.pin.oe  = 1'b1;
                    end
                    led_gpio_pin_strap_pkg::GIO_OPEN_DRAIN: begin
                        s_nxt.pin.out = 1'b0;
                        s_nxt.pin.oe  = ~i_gio_data_out;
                    end
                    default: s_nxt.pin = '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge i_clk) begin
        if (!i_external_reset_n) begin
            s_r           <= '0;
            s_r.st        <= led_gpio_pin_strap_pkg::ST_WAIT;
            s_r.strap     <= led_gpio_pin_strap_pkg::STRAP_RST;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from flops where data
    assign o_pin            = s_r.pin.out;
    assign o_pin_oe         = s_r.pin.oe;
    assign o_strap_latched  = s_r.st == led_gpio_pin_strap_pkg::ST_HELD;
    assign o_strap_captured = s_r.strap;
    assign o_gio_data_in    = s_r.gio_in;
    assign o_vphy_addr      = addr.vphy;
    assign o_port1_addr     = addr.port1;
    assign o_port2_addr     = addr.port2;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_external_reset_n);

    AST_STRAP_CAPTURE: assert property (
        $rose(o_strap_latched) |-> o_strap_captured == $past(i_addr_and_polarity_strap))
        else $error("strap not captured at release");
    AST_STRAP_HOLD: assert property (
        o_strap_latched && $past(o_strap_latched) |-> $stable(o_strap_captured))
        else $error("captured strap changed");
    AST_OVERRIDE: assert property (
        o_strap_latched && i_loader_ovr_valid |=> eff_strap == $past(i_loader_ovr_strap))
        else $error("override not applied");
    AST_ADDR_S0: assert property (
        !eff_strap |-> o_vphy_addr == 5'h00 && o_port1_addr == 5'h01 && o_port2_addr == 5'h02)
        else $error("wrong addresses for strap 0");
    AST_ADDR_S1: assert property (
        eff_strap |-> o_vphy_addr == 5'h01 && o_port1_addr == 5'h02 && o_port2_addr == 5'h03)
        else $error("wrong addresses for strap 1");
    AST_PUSH_PULL: assert property (
        o_strap_latched && i_indicator_enable && i_indicator_driver_function == 2'h0
        |=> o_pin_oe && o_pin == $past(i_indicator_active))
        else $error("push-pull indicator wrong");
    AST_OD_POLARITY: assert property (
        o_strap_latched && i_indicator_enable && i_indicator_driver_function != 2'h0
        && i_indicator_active |=> o_pin_oe && o_pin == !$past(eff_strap))
        else $error("open-drain indicator polarity wrong");
    AST_OD_RELEASE: assert property (
        i_indicator_enable && i_indicator_driver_function != 2'h0 && !i_indicator_active
        |=> !o_pin_oe)
        else $error("inactive open-drain indicator drives pin");
    AST_GIO_INPUT: assert property (
        !i_indicator_enable && !i_gio_dir_out |=> !o_pin_oe)
        else $error("gpio input drives pin");
    AST_GIO_OD: assert property (
        o_strap_latched && !i_indicator_enable && i_gio_dir_out && i_gio_open_drain
        |=> o_pin_oe == !$past(i_gio_data_out) && !o_pin)
        else $error("gpio open-drain wrong");

    // mode selection, polarity per strap level and the pre-capture guard
    AST_IND_DRIVES: assert property (
        o_strap_latched && i_indicator_enable && i_indicator_active |=> o_pin_oe)
        else $error("lit indicator does not drive pin");
    AST_OD_HIGH: assert property (
        o_strap_latched && !eff_strap && i_indicator_enable && i_indicator_driver_function != 2'h0
        && i_indicator_active |=> o_pin)
        else $error("strap 0 indicator not active high");
    AST_OD_LOW: assert property (
        o_strap_latched && eff_strap && i_indicator_enable && i_indicator_driver_function != 2'h0
        && i_indicator_active |=> !o_pin)
        else $error("strap 1 indicator not active low");
    AST_GIO_PP: assert property (
        o_strap_latched && !i_indicator_enable && i_gio_dir_out && !i_gio_open_drain
        |=> o_pin_oe && o_pin == $past(i_gio_data_out))
        else $error("gpio push-pull wrong");
    AST_GIO_SAMPLE: assert property (
        !i_indicator_enable && !i_gio_dir_out |=> o_gio_data_in == $past(i_pin))
        else $error("gpio input not sampled");
    AST_NO_DRIVE_EARLY: assert property (
        !o_strap_latched |=> !o_pin_oe)
        else $error("pin driven before strap capture");
    AST_OVR_IGNORED: assert property (
        !o_strap_latched |=> !s_r.ovr_valid)
        else $error("override taken before strap capture");

    // main scenarios: both polarities, override, general io output and strap 0
    COV_OD_LOW: cover property (o_strap_latched && eff_strap && o_pin_oe && !o_pin);
    COV_OD_HIGH: cover property (o_strap_latched && !eff_strap && o_pin_oe && o_pin);
    COV_STRAP_ZERO: cover property (o_strap_latched && !o_strap_captured);
    COV_OVERRIDE: cover property (o_strap_latched && i_loader_ovr_valid);
    COV_GIO_PP: cover property (!i_indicator_enable && i_gio_dir_out && !i_gio_open_drain);

endmodule

// ---- verif/pin_pull_model.sv ----
// board pull-up and external driver on the shared pin
`timescale 1ns/1ns
module pin_pull_model (
    // device side of the pin
    input  wire logic i_out,
    input  wire logic i_oe,
    // board driver used while the pin is an input
    input  wire logic i_ext_en,
    input  wire logic i_ext_val,
    // resolved pin level
    output logic      o_level
);
    // pull-up holds the level only when nobody drives; contention shows as unknown
    always_comb begin
        if (i_oe && i_ext_en) begin
            o_level = 1'bx;
        end else if (i_oe) begin
            o_level = i_out;
        end else if (i_ext_en) begin
            o_level = i_ext_val;
        end else begin
            o_level = 1'b1;
        end
    end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the indicator five / general io five pin mux
`timescale 1ns/1ns
module tb;
    logic       i_clk   = 1'b0;
    logic       i_external_reset_n  = 1'b0;
    logic       strap   = 1'b1;
    logic       ovr_v   = 1'b0;
    logic       ovr_s   = 1'b0;
    logic       ind_en  = 1'b0;
    logic [1:0] ind_fun = 2'h0;
    logic       ind_act = 1'b0;
    logic       dir_out = 1'b0;
    logic       od      = 1'b0;
    logic       dout    = 1'b0;
    logic       ext_en  = 1'b0;
    logic       ext_val = 1'b0;
    logic       pin, pin_q, pin_oe, latched, captured, din;
    logic [4:0] vphy, p1, p2;
    int         err_count   = 0;
    int         comparisons = 0;

    always #2 i_clk = ~i_clk;

    led_gpio_pin_strap_select dut_u (.i_clk(i_clk), .i_external_reset_n(i_external_reset_n),
        .i_addr_and_polarity_strap(strap), .i_loader_ovr_valid(ovr_v),
        .i_loader_ovr_strap(ovr_s), .i_indicator_enable(ind_en),
        .i_indicator_driver_function(ind_fun), .i_indicator_active(ind_act),
        .i_gio_dir_out(dir_out), .i_gio_open_drain(od), .i_gio_data_out(dout),
        .i_pin(pin), .o_pin(pin_q), .o_pin_oe(pin_oe), .o_strap_latched(latched),
        .o_strap_captured(captured), .o_gio_data_in(din), .o_vphy_addr(vphy),
        .o_port1_addr(p1), .o_port2_addr(p2));
    pin_pull_model pull_u (.i_out(pin_q), .i_oe(pin_oe), .i_ext_en(ext_en),
        .i_ext_val(ext_val), .o_level(pin));

    ////////////////////////////////////////////////////////////////////////////
    // inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask
    // address triple expected from the effective strap
    task automatic chk_addr(input logic s);
        logic [4:0] d;
        d = s ? led_gpio_pin_strap_pkg::ADDR_STEP_S1 : 5'h00;
        comparisons++;
        if ({vphy, p1, p2} !== {led_gpio_pin_strap_pkg::VPHY_ADDR_S0 + d,
            led_gpio_pin_strap_pkg::PORT1_ADDR_S0 + d,
            led_gpio_pin_strap_pkg::PORT2_ADDR_S0 + d}) begin
            err_count++;
            $display("CHECK FAILED %0t addresses %h %h %h", $time, vphy, p1, p2);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // reset with a pending override that must be ignored until the strap is held
    task automatic do_reset(input logic s);
        i_external_reset_n = 1'b0;
        strap = s;
        ovr_v = 1'b1;
        ovr_s = ~s;
        step(6);
        chk_bit(pin_oe, 1'b0, "oe in reset");
        chk_bit(latched, 1'b0, "latched in reset");
        chk_bit(captured, led_gpio_pin_strap_pkg::STRAP_RST, "strap in reset");
        chk_addr(led_gpio_pin_strap_pkg::STRAP_RST);
        i_external_reset_n = 1'b1;
        step(1);
        chk_bit(latched, 1'b1, "latched");
        chk_bit(captured, s, "captured");
        chk_addr(s);
        strap = ~s;
        ovr_v = 1'b0;
        step(1);
        chk_bit(captured, s, "strap hold");
    endtask
    // every function code, lit and dark; general io setup must not leak in
    task automatic t_indicator(input logic s);
        ind_en = 1'b1;
        dir_out = 1'b1;
        for (int i = 0; i < 8; i++) begin
            ind_fun = i[2:1];
            ind_act = i[0];
            step(1);
            chk_bit(pin_oe, (i[2:1] == 2'h0) | i[0], "ind oe");
            if (i[2:1] == 2'h0) begin
                chk_bit(pin_q, i[0], "push-pull");
            end else begin
                chk_bit(pin, i[0] ? ~s : 1'b1, "od level");
            end
        end
        ind_en = 1'b0;
    endtask
    // general io output kinds, then input with the board driving
    task automatic t_gio();
        for (int i = 0; i < 8; i++) begin
            {dir_out, od, dout} = i[2:0];
            step(1);
            chk_bit(pin_oe, i[2] & (~i[1] | ~i[0]), "gio oe");
            chk_bit(pin, i[2] ? i[0] : 1'b1, "gio level");
        end
        dir_out = 1'b0;
        ext_en = 1'b1;
        for (int v = 0; v < 2; v++) begin
            ext_val = v[0];
            step(1);
            chk_bit(din, v[0], "gio input");
        end
        ext_en = 1'b0;
    endtask
    // back-to-back overrides, last wins, and polarity follows them
    task automatic t_override(input logic s);
        ovr_v = 1'b1;
        ovr_s = s;
        step(1);
        ovr_s = ~s;
        step(1);
        ovr_v = 1'b0;
        chk_addr(~s);
        chk_bit(captured, s, "raw strap kept");
        {ind_en, ind_fun, ind_act} = {1'b1, 2'h1, 1'b1};
        step(1);
        chk_bit(pin_q, s, "override polarity");
        ind_en = 1'b0;
    endtask

    initial begin
        for (int k = 0; k < 2; k++) begin
            do_reset(~k[0]);
            t_indicator(~k[0]);
            t_gio();
            t_override(~k[0]);
        end
        close_out();
    end
endmodule
